// ==== core/mwf_fifo.sv ====
// byte fifo with valid and ready on both sides
`timescale 1ns/100ps
module mwf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic ready_r;

  // handshake decode
  wire push = in_valid && ready_r;
  wire pop = out_valid && out_ready;
  wire [AW:0] cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);

  assign in_ready = ready_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_ptr_r];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers, fill level and registered ready
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != FULL_CNT);
    end
  end
endmodule

// ==== core/mwf_host.sv ====
// host controller issuing range-write and range-fill commands
// Functional notes
// - flash first address must have its two lowest bits zero.
// - range-write arguments: first address bytes 0-3, length bytes 4-7.
// - range-write uses code 0x04, argument count 0x02, command framing 0x5A.
// - host sends data packets until exactly length_in_bytes bytes are delivered.
// - range-fill arguments: address 0-3, length 4-7, fill word 8-11.
// - range-fill length divisible by four; address should be word aligned; host checks the address for flash writes and flash fills.
// - eight-byte flash parts need length divisible by eight, address 64-bit; host checks length for fills only, address to 32 bits.
// - a byte fill value is repeated in all four fill word bytes.
// - a halfword fill value is placed in both fill word halves.
// - host must have every affected flash sector erased beforehand.
// - range-fill uses code 0x05, argument count 0x03, length 0x10 0x00.
`timescale 1ns/100ps
module mwf_host
  import mwf_pkg::*;
#(
  parameter int DATA_PKT = MWF_DATA_PKT,
  parameter int FIFO_DEPTH = MWF_FIFO_DEPTH,
  parameter bit EIGHT_BYTE_FLASH = 1'b0
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // command request
  input wire logic START,
  input wire logic FILL,
  input wire logic TO_FLASH,
  input wire logic ERASED,
  input wire logic [31:0] ADDR,
  input wire logic [31:0] COUNT,
  input wire logic [31:0] PATTERN,
  input wire logic [1:0] FILL_WIDTH,
  // command result
  output logic BUSY,
  output logic DONE,
  output logic OK,
  output logic [31:0] STATUS,
  // write data stream
  input wire logic [7:0] DIN,
  input wire logic DIN_VALID,
  output logic DIN_READY,
  // byte stream towards the framing layer
  output logic [7:0] TX_DATA,
  output logic [7:0] TX_TYPE,
  output logic TX_VALID,
  output logic TX_LAST,
  input wire logic TX_READY,
  // reply stream from the framing layer
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_LAST
);
  // last position inside a data packet; a longer write is cut into several
  // packets so the target never has to buffer more than one of them
  localparam logic [31:0] PKT_LAST = 32'(DATA_PKT - 1);

  // build the 32-bit fill word from the chosen width
  function automatic logic [31:0] fill_word(input logic [1:0] w, input logic [31:0] p);
    logic [31:0] r;
    r = p;
    if (w == MWF_FILL_BYTE) begin
      r = {4{p[7:0]}};
    end else if (w == MWF_FILL_HALF) begin
      r = {2{p[15:0]}};
    end
    return r;
  endfunction

  // pick one little-endian byte from a 32-bit word
  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] b);
    return w[b*8 +: 8];
  endfunction

  mwf_state_t state_r;
  mwf_state_t state_nxt;
  logic fill_r;
  logic flash_r;
  logic erased_r;
  logic [31:0] addr_r;
  logic [31:0] count_r;
  logic [31:0] word_r;
  logic [31:0] idx_r;
  logic [31:0] pkt_r;
  logic [7:0] tx_data_r;
  logic [7:0] tx_type_r;
  logic tx_valid_r;
  logic tx_last_r;
  logic busy_r;
  logic done_r;
  logic ok_r;
  logic [31:0] status_r;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_in_ready;
  logic stat_valid;
  logic [31:0] stat_word;

  // write data buffer; a stalled link fills it and stops the source
  // bytes pushed beyond the requested length stay queued for the next write
  mwf_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rstn(RSTN),
    .in_data(DIN),
    .in_valid(DIN_VALID),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  // reply status extraction
  mwf_reply u_reply (
    .clk(CLK),
    .rstn(RSTN),
    .rx_data(RX_DATA),
    .rx_valid(RX_VALID),
    .rx_last(RX_LAST),
    .stat_valid(stat_valid),
    .stat_word(stat_word)
  );

  // request checks made before any byte leaves, so a refused command
  // never reaches the target
  wire bad_align = flash_r && (addr_r[1:0] != 2'b00);
  wire bad_fill4 = fill_r && (count_r[1:0] != 2'b00);
  wire bad_fill8 = fill_r && EIGHT_BYTE_FLASH && flash_r && (count_r[2:0] != 3'b000);
  wire not_erased = flash_r && !erased_r;
  // the target pads and verifies flash itself, so only what the host
  // promises is vetted here; protection is left to the target's status
  wire refuse = bad_align || bad_fill4 || bad_fill8 || not_erased;
  wire [31:0] refuse_code = bad_align ? MWF_ST_ALIGN :
                            (bad_fill4 || bad_fill8) ? MWF_ST_HOST_COUNT : MWF_ST_HOST_ERASE;

  // command packet layout
  wire [7:0] cmd_code = fill_r ? MWF_CODE_FILL : MWF_CODE_WRITE;
  wire [7:0] cmd_args = fill_r ? MWF_ARGS_FILL : MWF_ARGS_WRITE;
  wire [7:0] cmd_len = fill_r ? MWF_LEN_FILL : MWF_LEN_WRITE;
  wire [7:0] cmd_pos = idx_r[7:0];
  wire cmd_end = (cmd_pos == cmd_len - 8'h01);

  // byte selection within the command packet
  wire [7:0] arg_byte = (cmd_pos >= MWF_POS_FILL) ? word_byte(word_r, cmd_pos[1:0]) :
                        (cmd_pos >= MWF_POS_COUNT) ? word_byte(count_r, cmd_pos[1:0]) :
                        word_byte(addr_r, cmd_pos[1:0]);
  wire [7:0] cmd_byte = (cmd_pos == 8'h00) ? cmd_code :
                        (cmd_pos == 8'h01) ? MWF_FLAGS :
                        (cmd_pos == 8'h02) ? MWF_RESERVED :
                        (cmd_pos == 8'h03) ? cmd_args : arg_byte;

  // transmit slot: a new byte loads when the slot is empty or being taken
  // with the slot reloading on the taking edge the link can run one byte
  // a cycle; a stalled link simply leaves the byte standing
  wire slot_free = !tx_valid_r || TX_READY;
  wire load_cmd = (state_r == MWF_CMD) && slot_free;
  wire load_data = (state_r == MWF_DATA) && slot_free && fifo_valid;
  wire data_end = (idx_r == count_r - 32'h1);
  wire pkt_end = (pkt_r == PKT_LAST) || data_end;
  wire has_data = !fill_r && (count_r != '0);
  wire tx_drained = !tx_valid_r || TX_READY;

  assign fifo_ready = load_data;
  assign BUSY = busy_r;
  assign DONE = done_r;
  assign OK = ok_r;
  assign STATUS = status_r;
  assign DIN_READY = fifo_in_ready;
  assign TX_DATA = tx_data_r;
  assign TX_TYPE = tx_type_r;
  assign TX_VALID = tx_valid_r;
  assign TX_LAST = tx_last_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MWF_IDLE: begin
        if (START) begin
          state_nxt = MWF_CHECK;
        end
      end
      MWF_CHECK: begin
        state_nxt = refuse ? MWF_IDLE : MWF_CMD;
      end
      MWF_CMD: begin
        if (load_cmd && cmd_end) begin
          state_nxt = has_data ? MWF_DATA : MWF_REPLY;
        end
      end
      MWF_DATA: begin
        if (load_data && data_end) begin
          state_nxt = MWF_REPLY;
        end
      end
      // no timeout: a lost reply holds the controller here until reset
      MWF_REPLY: begin
        if (stat_valid && tx_drained) begin
          state_nxt = MWF_IDLE;
        end
      end
      default: begin
        state_nxt = MWF_IDLE;
      end
    endcase
  end

  // state and request capture
  // the request is latched once, so inputs may change while busy
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= MWF_IDLE;
      fill_r <= 1'b0;
      flash_r <= 1'b0;
      erased_r <= 1'b0;
      addr_r <= '0;
      count_r <= '0;
      word_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == MWF_IDLE && START) begin
        fill_r <= FILL;
        flash_r <= TO_FLASH;
        erased_r <= ERASED;
        addr_r <= ADDR;
        count_r <= COUNT;
        word_r <= fill_word(FILL_WIDTH, PATTERN);
      end
    end
  end

  // byte counters: position in command, data total and data packet
  // idx restarts after the command packet so it counts data bytes only;
  // the check state clears both so a refused request leaves no residue
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      idx_r <= '0;
      pkt_r <= '0;
    end else if (state_r == MWF_CHECK || (load_cmd && cmd_end)) begin
      idx_r <= '0;
      pkt_r <= '0;
    end else if (load_cmd || load_data) begin
      idx_r <= idx_r + 32'h1;
      pkt_r <= (load_data && pkt_end) ? '0 : pkt_r + 32'h1;
    end
  end

  // transmit register towards the framing layer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_data_r <= '0;
      tx_type_r <= '0;
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
    end else if (load_cmd) begin
      tx_data_r <= cmd_byte;
      tx_type_r <= MWF_FRAME_CMD;
      tx_valid_r <= 1'b1;
      tx_last_r <= cmd_end;
    end else if (load_data) begin
      tx_data_r <= fifo_data;
      tx_type_r <= MWF_FRAME_DATA;
      tx_valid_r <= 1'b1;
      tx_last_r <= pkt_end;
    end else if (TX_READY) begin
      tx_valid_r <= 1'b0;
      tx_last_r <= 1'b0;
    end
  end

  // result reporting; the target's own status covers protection and verify
  // busy follows the next state, so it falls on the very edge that raises done;
  // ok and status stand until the next command ends
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ok_r <= 1'b0;
      status_r <= '0;
    end else begin
      busy_r <= (state_nxt != MWF_IDLE);
      done_r <= 1'b0;
      if (state_r == MWF_CHECK && refuse) begin
        done_r <= 1'b1;
        ok_r <= 1'b0;
        status_r <= refuse_code;
      end else if (state_r == MWF_REPLY && stat_valid && tx_drained) begin
        done_r <= 1'b1;
        ok_r <= (stat_word == MWF_ST_SUCCESS);
        status_r <= stat_word;
      end
    end
  end
endmodule

// ==== core/mwf_pkg.sv ====
// constants shared by the memory write and fill command host
package mwf_pkg;
  // command codes and argument counts
  localparam logic [7:0] MWF_CODE_WRITE = 8'h04;
  localparam logic [7:0] MWF_CODE_FILL = 8'h05;
  localparam logic [7:0] MWF_ARGS_WRITE = 8'h02;
  localparam logic [7:0] MWF_ARGS_FILL = 8'h03;
  // command packet header bytes
  localparam logic [7:0] MWF_FLAGS = 8'h00;
  localparam logic [7:0] MWF_RESERVED = 8'h00;
  localparam int MWF_HDR_BYTES = 4;
  localparam int MWF_ARG_BYTES = 4;
  // command packet length: header plus four bytes per argument
  localparam logic [7:0] MWF_LEN_WRITE = 8'h0C;
  localparam logic [7:0] MWF_LEN_FILL = 8'h10;
  // byte positions of the arguments inside the command packet
  localparam logic [7:0] MWF_POS_ADDR = 8'h04;
  localparam logic [7:0] MWF_POS_COUNT = 8'h08;
  localparam logic [7:0] MWF_POS_FILL = 8'h0C;
  // framing: start byte and packet types handed to the framing layer
  localparam logic [7:0] MWF_FRAME_START = 8'h5A;
  localparam logic [7:0] MWF_FRAME_CMD = 8'hA4;
  localparam logic [7:0] MWF_FRAME_DATA = 8'hA5;
  // reply packet layout
  localparam logic [7:0] MWF_REPLY_TAG = 8'hA0;
  localparam logic [3:0] MWF_REPLY_STAT_POS = 4'h4;
  localparam logic [3:0] MWF_REPLY_MIN_LEN = 4'h8;
  // status codes
  localparam logic [31:0] MWF_ST_SUCCESS = 32'h0000_0000;
  localparam logic [31:0] MWF_ST_ALIGN = 32'h0000_0065;
  localparam logic [31:0] MWF_ST_HOST_COUNT = 32'h0001_0001;
  localparam logic [31:0] MWF_ST_HOST_ERASE = 32'h0001_0002;
  // fill width selections
  localparam logic [1:0] MWF_FILL_BYTE = 2'h0;
  localparam logic [1:0] MWF_FILL_HALF = 2'h1;
  // default data packet payload size and fifo depth
  localparam int MWF_DATA_PKT = 32;
  localparam int MWF_FIFO_DEPTH = 8;
  // controller states
  typedef enum logic [2:0] {
    MWF_IDLE, MWF_CHECK, MWF_CMD, MWF_DATA, MWF_REPLY
  } mwf_state_t;
endpackage

// ==== core/mwf_reply.sv ====
// parser that pulls the status word out of a reply packet
`timescale 1ns/100ps
module mwf_reply
  import mwf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // reply byte stream
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  // parsed result
  output logic stat_valid,
  output logic [31:0] stat_word
);
  logic [3:0] pos_r;
  logic tag_ok_r;
  logic [31:0] stat_r;
  logic stat_valid_r;

  // byte position decode; the status word sits at bytes four to seven
  wire in_stat = (pos_r >= MWF_REPLY_STAT_POS) && (pos_r < MWF_REPLY_MIN_LEN);
  wire [1:0] lane = pos_r[1:0];
  wire long_enough = (pos_r >= MWF_REPLY_MIN_LEN - 4'h1);
  wire [3:0] pos_inc = (pos_r == 4'hF) ? pos_r : pos_r + 4'h1;

  assign stat_valid = stat_valid_r;
  assign stat_word = stat_r;

  // collect bytes, little endian, and flag a complete reply
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_r <= '0;
      tag_ok_r <= 1'b0;
      stat_r <= '0;
      stat_valid_r <= 1'b0;
    end else begin
      stat_valid_r <= 1'b0;
      if (rx_valid) begin
        if (pos_r == '0) begin
          tag_ok_r <= (rx_data == MWF_REPLY_TAG);
        end
        if (in_stat) begin
          stat_r[lane*8 +: 8] <= rx_data;
        end
        pos_r <= rx_last ? '0 : pos_inc;
        stat_valid_r <= rx_last && tag_ok_r && long_enough;
      end
    end
  end
endmodule

// ==== testbench/mwf_host_properties.sv ====
// assertion checker for the write and fill command host
`timescale 1ns/100ps
module mwf_host_properties
  import mwf_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // request
  input wire logic START,
  input wire logic FILL,
  input wire logic TO_FLASH,
  input wire logic [31:0] ADDR,
  // result
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic OK,
  input wire logic [31:0] STATUS,
  // framing side
  input wire logic [7:0] TX_DATA,
  input wire logic [7:0] TX_TYPE,
  input wire logic TX_VALID,
  input wire logic TX_LAST,
  input wire logic TX_READY
);
  logic fill_r;
  logic first_r;
  wire take = START && !BUSY;
  wire bad_align = take && TO_FLASH && (ADDR[1:0] != 2'b00);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // kind of the running command and whether its first byte is still due
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fill_r <= 1'b0;
      first_r <= 1'b0;
    end else if (take) begin
      fill_r <= FILL;
      first_r <= 1'b1;
    end else if (TX_VALID && TX_READY) begin
      first_r <= 1'b0;
    end
  end
  AST_ALIGN_REFUSE: assert property (bad_align |-> ##2 DONE && STATUS == MWF_ST_ALIGN)
    else $error("unaligned flash address not refused");
  AST_ALIGN_SILENT: assert property (bad_align |-> !TX_VALID [*3])
    else $error("bytes sent for a refused command");
  AST_FIRST_CODE: assert property (TX_VALID && first_r |->
    TX_TYPE == MWF_FRAME_CMD && TX_DATA == (fill_r ? MWF_CODE_FILL : MWF_CODE_WRITE))
    else $error("wrong first command byte");
  AST_FILL_NO_DATA: assert property (TX_VALID && fill_r |-> TX_TYPE == MWF_FRAME_CMD)
    else $error("data packet during fill");
  AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("byte changed while stalled");
  AST_DONE_PULSE: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  AST_OK_STATUS: assert property (DONE |-> OK == (STATUS == MWF_ST_SUCCESS))
    else $error("ok disagrees with status");
  AST_BUSY_RISE: assert property (take |=> BUSY)
    else $error("busy did not rise");
  AST_BUSY_FALL: assert property ($fell(BUSY) |-> DONE)
    else $error("busy fell without done");
endmodule

bind mwf_host mwf_host_properties u_mwf_host_properties (.CLK(CLK), .RSTN(RSTN),
  .START(START), .FILL(FILL), .TO_FLASH(TO_FLASH), .ADDR(ADDR), .BUSY(BUSY),
  .DONE(DONE), .OK(OK), .STATUS(STATUS), .TX_DATA(TX_DATA), .TX_TYPE(TX_TYPE),
  .TX_VALID(TX_VALID), .TX_LAST(TX_LAST), .TX_READY(TX_READY));

// ==== testbench/mwf_target.sv ====
// target model: decodes command packets, stores memory bytes, replies
`timescale 1ns/100ps
module mwf_target
  import mwf_pkg::*;
#(
  parameter logic [31:0] FLASH_TOP = 32'h1000_0000,
  parameter logic [31:0] PROT_ST = 32'h0000_0068
) (
  // clock, reset and scenario controls
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic protect,
  input wire logic verify,
  // bytes from the host
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  // reply to the host
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last
);
  logic [7:0] cmd [0:15];
  logic [7:0] got [$];
  int clen = 0;
  int pos = 0;
  int n_cmd = 0;
  int n_verify = 0;
  logic [7:0] b;
  logic l;
  logic [31:0] a;
  logic [31:0] st;
  // take one byte; ready toggles when slow to stall the host
  task automatic get_byte();
    bit hit;
    hit = 0;
    while (!hit) begin
      @(posedge clk);
      hit = tx_valid && tx_ready;
      b = tx_data;
      l = tx_last;
      tx_ready <= !slow || !tx_ready;
    end
  endtask
  // one command per pass: header, data phase, memory update, reply
  initial begin
    tx_ready = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    wait (rstn === 1'b1);
    forever begin
      pos = 0;
      l = 1'b0;
      while (!l) begin
        get_byte();
        if (pos == 0) got.delete();
        if (pos < 16) cmd[pos] = b;
        pos++;
      end
      // clen keeps the last header length until the next header is complete
      clen = pos;
      n_cmd++;
      a = {cmd[7], cmd[6], cmd[5], cmd[4]};
      st = (a < FLASH_TOP && protect) ? PROT_ST : MWF_ST_SUCCESS;
      for (int i = 0; i < {cmd[11], cmd[10], cmd[9], cmd[8]}; i++) begin
        if (cmd[0] == MWF_CODE_WRITE) get_byte();
        else b = cmd[12 + i % 4];
        if (st == 0) got.push_back(b);
      end
      if (a < FLASH_TOP && st == 0) begin
        while (got.size() % 4 != 0) got.push_back(8'hFF);
        if (verify) n_verify++;
      end
      for (int i = 0; i < 8; i++) begin
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data <= (i == 0) ? MWF_REPLY_TAG : (i == 3) ? 8'h02 : (i > 3) ? st[8*(i-4) +: 8] : 8'h00;
        rx_last <= (i == 7);
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// testbench for the write and fill command host
`timescale 1ns/100ps
module tb_top
  import mwf_pkg::*;
;
  logic clk, rstn, start, fill, to_flash, erased, slow, protect, verify;
  logic [31:0] addr, count, pattern, status;
  logic [1:0] fill_width;
  logic busy, done, ok, din_valid, din_ready, tx_valid, tx_last, tx_ready, rx_valid, rx_last;
  logic [7:0] din, tx_data, tx_type, rx_data;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  mwf_host u_mwf_host (.CLK(clk), .RSTN(rstn), .START(start), .FILL(fill),
    .TO_FLASH(to_flash), .ERASED(erased), .ADDR(addr), .COUNT(count), .PATTERN(pattern),
    .FILL_WIDTH(fill_width), .BUSY(busy), .DONE(done), .OK(ok), .STATUS(status),
    .DIN(din), .DIN_VALID(din_valid), .DIN_READY(din_ready), .TX_DATA(tx_data),
    .TX_TYPE(tx_type), .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_LAST(rx_last));
  mwf_target u_target (.clk(clk), .rstn(rstn), .slow(slow), .protect(protect),
    .verify(verify), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last));
  // 50 MHz clock and a cycle ceiling against hangs
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[ERR] %0t cycle limit reached", $time);
      summarize();
    end
  end
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, act, exp);
    end
  endtask
  // hold one write byte until the fifo takes it
  task automatic push(input logic [7:0] v);
    din = v;
    din_valid = 1'b1;
    do @(posedge clk); while (din_ready !== 1'b1);
    @(negedge clk);
  endtask
  // issue one command and wait for its completion pulse
  task automatic run(input logic f, fl, er, input logic [31:0] a, c, p,
                     input logic [1:0] w, input logic [31:0] exp);
    int k;
    {fill, to_flash, erased, addr, count, pattern, fill_width} = {f, fl, er, a, c, p, w};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) begin
      n_errors++;
      $display("[ERR] %0t no done pulse", $time);
    end
    chk(status, exp);
    chk(ok, exp == 0);
  endtask
  task automatic chk_cmd(input logic [7:0] code, input logic [31:0] a, c, p);
    logic [127:0] e;
    int n;
    n = (code == MWF_CODE_FILL) ? 16 : 12;
    e = {p, c, a, (code == MWF_CODE_FILL) ? 8'h03 : 8'h02, 16'h0000, code};
    chk(u_target.clen, n);
    for (int i = 0; i < n; i++) chk(u_target.cmd[i], e[8*i +: 8]);
  endtask
  // full fifo, then an unaligned ram write drains it under stalls
  task automatic t_ram_write();
    slow = 1'b1;
    for (int i = 0; i < MWF_FIFO_DEPTH; i++) push(8'h30 + 8'(i));
    din_valid = 1'b0;
    @(negedge clk);
    chk(din_ready, 1'b0);
    run(0, 0, 0, 32'h2000_0401, 32'h0000_0008, 0, 0, MWF_ST_SUCCESS);
    chk_cmd(MWF_CODE_WRITE, 32'h2000_0401, 32'h0000_0008, 0);
    chk(u_target.got.size(), 8);
    for (int i = 0; i < 8; i++) chk(u_target.got[i], 8'h30 + 8'(i));
    chk(din_ready, 1'b1);
    slow = 1'b0;
  endtask
  // flash write of six bytes is padded and verified
  task automatic t_flash_write();
    int n;
    verify = 1'b1;
    for (int i = 0; i < 6; i++) push(8'hA0 + 8'(i));
    din_valid = 1'b0;
    n = u_target.n_verify;
    run(0, 1, 1, 32'h0000_1000, 32'h0000_0006, 0, 0, MWF_ST_SUCCESS);
    chk(u_target.n_verify, n + 1);
    chk(u_target.got.size(), 8);
    for (int i = 0; i < 8; i++) chk(u_target.got[i], (i < 6) ? 8'hA0 + 8'(i) : 8'hFF);
  endtask
  // byte, halfword and word fills into flash
  task automatic t_fill();
    logic [31:0] pat [3] = '{32'h0000_00FE, 32'h0000_5AFE, 32'h1234_5678};
    logic [31:0] wrd [3] = '{32'hFEFE_FEFE, 32'h5AFE_5AFE, 32'h1234_5678};
    for (int j = 0; j < 3; j++) begin
      run(1, 1, 1, 32'h0000_2000, 32'h0000_0008, pat[j], 2'(j), 0);
      chk_cmd(MWF_CODE_FILL, 32'h0000_2000, 32'h0000_0008, wrd[j]);
      chk(u_target.got.size(), 8);
      for (int i = 0; i < 8; i++) chk(u_target.got[i], wrd[j][8*(i%4) +: 8]);
    end
  endtask
  // back-to-back host refusals send nothing; protected flash fails at the target
  task automatic t_refuse();
    int n;
    n = u_target.n_cmd;
    run(0, 1, 1, 32'h0000_1002, 32'h0000_0004, 0, 0, MWF_ST_ALIGN);
    run(1, 0, 1, 32'h2000_0000, 32'h0000_0006, 0, 2, MWF_ST_HOST_COUNT);
    run(0, 1, 0, 32'h0000_1000, 32'h0000_0004, 0, 0, MWF_ST_HOST_ERASE);
    chk(u_target.n_cmd, n);
    protect = 1'b1;
    for (int i = 0; i < 4; i++) push(8'h11);
    din_valid = 1'b0;
    run(0, 1, 1, 32'h0000_1000, 32'h0000_0004, 0, 0, 32'h0000_0068);
    chk(u_target.got.size(), 0);
    protect = 1'b0;
  endtask
  initial begin
    {rstn, start, fill, to_flash, erased, slow, protect, verify, din_valid} = '0;
    {addr, count, pattern, fill_width, din} = '0;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_ram_write();
    t_flash_write();
    t_fill();
    t_refuse();
    summarize();
  end
endmodule
